/* File: verilog/interval_timer_pkg.sv */
// Package for the periodic interval timer: register map, field positions,
// reset values and bus response codes.
// Assumes a 32-bit AXI4-Lite register bus with word-aligned registers.
package interval_timer_pkg;

  localparam int          COUNT_WIDTH      = 16;
  localparam int          ADDR_WIDTH       = 8;
  localparam int          DATA_WIDTH       = 32;

  localparam int          MASTER_CLOCK_HZ  = 25000000;
  localparam int          SLOW_CLOCK_HZ    = 32768;

  localparam logic [7:0]  OFFS_RELOAD      = 8'h04;
  localparam logic [7:0]  OFFS_STATUS      = 8'h10;
  localparam logic [7:0]  OFFS_INT_ENABLE  = 8'h14;
  localparam logic [7:0]  OFFS_INT_DISABLE = 8'h18;
  localparam logic [7:0]  OFFS_INT_MASK    = 8'h1C;

  localparam int          BIT_PERIOD_ELAPSED = 0;

  localparam logic [15:0] RESET_RELOAD     = 16'h0000;
  localparam logic [15:0] COUNT_LAST       = 16'h0001;
  localparam logic [15:0] COUNT_STEP       = 16'h0001;

  localparam logic [1:0]  RESP_OKAY        = 2'h0;
  localparam logic [1:0]  RESP_SLVERR      = 2'h2;

  typedef struct packed {
    logic        period_elapsed_flag;
    logic        int_enabled;
  } timer_state_type;

endpackage

/* File: verilog/slow_clock_tick.sv */
// Turns the slow clock pin into a one-cycle tick on the master clock.
// Assumes the pin is far slower than aclk, so each rising edge is seen.
`timescale 1ns/1ps
module slow_clock_tick (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic slow_clock,
  output logic      tick
);

  logic sync1_ff;
  logic sync2_ff;
  logic sync3_ff;
  logic level_ff;
  logic tick_ff;

  wire  agree    = sync2_ff == sync3_ff;
  wire  nxt_level = agree ? sync3_ff : level_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
      sync3_ff <= 1'b0;
      level_ff <= 1'b0;
      tick_ff  <= 1'b0;
    end else begin
      sync1_ff <= slow_clock;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
      level_ff <= nxt_level;
      tick_ff  <= nxt_level & ~level_ff;
    end
  end

  assign tick = tick_ff;

endmodule

/* File: verilog/periodic_interval_timer.sv */
// Periodic interval timer with an AXI4-Lite register slave.
// Assumes slow_clock is an asynchronous pin and other_irq are the
// interrupt lines of the other system peripherals, same clock domain.
// Function
// - 16-bit down counter loaded from reload register
// - Reload resets to zero, meaning longest period
// - Zero sets flag; interrupt only when enabled
// - Counter reloads itself and keeps counting
// - Reload register write restarts counter immediately
// - Counts only on the free-running slow clock
// - Interrupt ORed with other system peripherals
// - Zero gives 65536 ticks, else value ticks
//
// Local design decisions: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
module periodic_interval_timer
  import interval_timer_pkg::*;
#(
  parameter int OTHER_IRQS = 3
) (
  input  wire logic                                      aclk,
  input  wire logic                                      aresetn,
  input  wire logic [interval_timer_pkg::ADDR_WIDTH-1:0] s_axi_awaddr,
  input  wire logic                                      s_axi_awvalid,
  output logic                                           s_axi_awready,
  input  wire logic [interval_timer_pkg::DATA_WIDTH-1:0] s_axi_wdata,
  input  wire logic [3:0]                                s_axi_wstrb,
  input  wire logic                                      s_axi_wvalid,
  output logic                                           s_axi_wready,
  output logic [1:0]                                     s_axi_bresp,
  output logic                                           s_axi_bvalid,
  input  wire logic                                      s_axi_bready,
  input  wire logic [interval_timer_pkg::ADDR_WIDTH-1:0] s_axi_araddr,
  input  wire logic                                      s_axi_arvalid,
  output logic                                           s_axi_arready,
  output logic [interval_timer_pkg::DATA_WIDTH-1:0]      s_axi_rdata,
  output logic [1:0]                                     s_axi_rresp,
  output logic                                           s_axi_rvalid,
  input  wire logic                                      s_axi_rready,
  input  wire logic                                      slow_clock,
  input  wire logic [OTHER_IRQS-1:0]                     other_irq,
  output logic                                           timer_irq,
  output logic                                           system_irq
);

  import interval_timer_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Declarations

  logic [ADDR_WIDTH-1:0]  awaddr_ff;
  logic [DATA_WIDTH-1:0]  wdata_ff;
  logic [3:0]             wstrb_ff;
  logic                   aw_held_ff;
  logic                   w_held_ff;
  logic                   awready_ff;
  logic                   wready_ff;
  logic                   bvalid_ff;
  logic [1:0]             bresp_ff;
  logic                   arready_ff;
  logic                   rvalid_ff;
  logic [1:0]             rresp_ff;
  logic [DATA_WIDTH-1:0]  rdata_ff;
  logic [COUNT_WIDTH-1:0] period_reload_value_ff;
  logic [COUNT_WIDTH-1:0] period_tick_counter_ff;
  timer_state_type        state_ff;
  logic                   timer_irq_ff;
  logic                   system_irq_ff;
  logic                   tick;

  function automatic logic is_mapped(input logic [ADDR_WIDTH-1:0] a);
    is_mapped = a == OFFS_RELOAD || a == OFFS_STATUS || a == OFFS_INT_ENABLE ||
                a == OFFS_INT_DISABLE || a == OFFS_INT_MASK;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Slow clock tick

  slow_clock_tick u_tick (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .slow_clock (slow_clock),
    .tick       (tick)
  );

  ////////////////////////////////////////////////////////////////////////
  // Write channel

  // Address and data may come in either order; the write waits for both
  wire aw_hs        = s_axi_awvalid & awready_ff;
  wire w_hs         = s_axi_wvalid & wready_ff;
  wire b_hs         = bvalid_ff & s_axi_bready;
  wire do_write     = aw_held_ff & w_held_ff & ~bvalid_ff;
  wire nxt_aw_held  = (aw_held_ff | aw_hs) & ~do_write;
  wire nxt_w_held   = (w_held_ff | w_hs) & ~do_write;
  wire nxt_bvalid   = (bvalid_ff & ~b_hs) | do_write;

  wire wr_reload    = do_write && awaddr_ff == OFFS_RELOAD && wstrb_ff[1:0] != 2'h0;
  wire wr_enable    = do_write && awaddr_ff == OFFS_INT_ENABLE && wstrb_ff[0] &&
                      wdata_ff[BIT_PERIOD_ELAPSED];
  wire wr_disable   = do_write && awaddr_ff == OFFS_INT_DISABLE && wstrb_ff[0] &&
                      wdata_ff[BIT_PERIOD_ELAPSED];

  wire [COUNT_WIDTH-1:0] nxt_period_reload_value = {
    wstrb_ff[1] ? wdata_ff[15:8] : period_reload_value_ff[15:8],
    wstrb_ff[0] ? wdata_ff[7:0]  : period_reload_value_ff[7:0]};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff <= 1'b0;
      w_held_ff  <= 1'b0;
      awready_ff <= 1'b0;
      wready_ff  <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= RESP_OKAY;
      awaddr_ff  <= '0;
      wdata_ff   <= '0;
      wstrb_ff   <= 4'h0;
    end else begin
      aw_held_ff <= nxt_aw_held;
      w_held_ff  <= nxt_w_held;
      awready_ff <= ~nxt_aw_held & ~nxt_bvalid;
      wready_ff  <= ~nxt_w_held & ~nxt_bvalid;
      bvalid_ff  <= nxt_bvalid;
      if (aw_hs) begin
        awaddr_ff <= s_axi_awaddr;
      end
      if (w_hs) begin
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (do_write) begin
        bresp_ff <= is_mapped(awaddr_ff) ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read channel

  wire ar_hs        = s_axi_arvalid & arready_ff;
  wire r_hs         = rvalid_ff & s_axi_rready;
  wire nxt_rvalid   = (rvalid_ff & ~r_hs) | ar_hs;
  wire rd_status    = ar_hs && s_axi_araddr == OFFS_STATUS;

  wire [DATA_WIDTH-1:0] rd_word =
    s_axi_araddr == OFFS_RELOAD   ? {16'h0000, period_reload_value_ff} :
    s_axi_araddr == OFFS_STATUS   ? {31'h00000000, state_ff.period_elapsed_flag} :
    s_axi_araddr == OFFS_INT_MASK ? {31'h00000000, state_ff.int_enabled} :
                                    32'h00000000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b0;
      rresp_ff   <= RESP_OKAY;
      rdata_ff   <= '0;
    end else begin
      arready_ff <= ~nxt_rvalid;
      rvalid_ff  <= nxt_rvalid;
      if (ar_hs) begin
        rdata_ff <= rd_word;
        rresp_ff <= is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Down counter and flag

  // The flag rises on the tick at a count of one, which reloads the count.
  // A count of zero wraps to all ones, so a zero reload gives the
  // longest period; reset leaves the count at zero for the same reason.
  wire reach_zero = tick && period_tick_counter_ff == COUNT_LAST;

  wire [COUNT_WIDTH-1:0] nxt_period_tick_counter =
    wr_reload  ? nxt_period_reload_value :
    reach_zero ? period_reload_value_ff :
    tick       ? period_tick_counter_ff - COUNT_STEP :
                 period_tick_counter_ff;

  // A new period wins over a clearing status read in the same cycle
  wire nxt_flag    = reach_zero | (state_ff.period_elapsed_flag & ~rd_status);
  wire nxt_enabled = wr_enable | (state_ff.int_enabled & ~wr_disable);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      period_reload_value_ff <= RESET_RELOAD;
      period_tick_counter_ff <= RESET_RELOAD;
      state_ff               <= '0;
      timer_irq_ff           <= 1'b0;
      system_irq_ff          <= 1'b0;
    end else begin
      if (wr_reload) begin
        period_reload_value_ff <= nxt_period_reload_value;
      end
      period_tick_counter_ff <= nxt_period_tick_counter;
      state_ff.period_elapsed_flag <= nxt_flag;
      state_ff.int_enabled         <= nxt_enabled;
      timer_irq_ff  <= nxt_flag & nxt_enabled;
      system_irq_ff <= (nxt_flag & nxt_enabled) | (|other_irq);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  assign s_axi_awready = awready_ff;
  assign s_axi_wready  = wready_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rresp   = rresp_ff;
  assign s_axi_rdata   = rdata_ff;
  assign timer_irq     = timer_irq_ff;
  assign system_irq    = system_irq_ff;

endmodule

/* File: test/pit_sva.sv */
// Checker for the periodic interval timer's bus and interrupt ports.
// Assumes it is bound to the timer's top module.
`timescale 1ns/1ps
module pit_sva
  import interval_timer_pkg::*;
#(
  parameter int OTHER_IRQS = 3
) (
  input wire logic                  aclk,
  input wire logic                  aresetn,
  input wire logic                  s_axi_awvalid,
  input wire logic                  s_axi_awready,
  input wire logic                  s_axi_wvalid,
  input wire logic                  s_axi_wready,
  input wire logic [1:0]            s_axi_bresp,
  input wire logic                  s_axi_bvalid,
  input wire logic                  s_axi_bready,
  input wire logic [7:0]            s_axi_araddr,
  input wire logic                  s_axi_arvalid,
  input wire logic                  s_axi_arready,
  input wire logic [1:0]            s_axi_rresp,
  input wire logic                  s_axi_rvalid,
  input wire logic                  s_axi_rready,
  input wire logic [OTHER_IRQS-1:0] other_irq,
  input wire logic                  timer_irq,
  input wire logic                  system_irq
);
  default clocking dc @(posedge aclk); endclocking
  default disable iff (!aresetn);
  aw_taken_a: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("awready stays high after a take");
  write_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:3] s_axi_bvalid) else $error("write response late");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  read_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rresp))
    else $error("read response dropped");
  bad_addr_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h20
    |=> s_axi_rresp == RESP_SLVERR) else $error("unmapped read not refused");
  other_or_a: assert property (|other_irq |=> system_irq)
    else $error("other interrupt not passed on");
  timer_or_a: assert property (timer_irq |-> ##[0:1] system_irq)
    else $error("timer interrupt not passed on");
  quiet_irq_a: assert property ((!timer_irq && other_irq == '0)[*2] |-> !system_irq)
    else $error("system interrupt without source");
  cover property (timer_irq && system_irq);
  cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == RESP_SLVERR);
  cover property ($rose(timer_irq));
endmodule
bind periodic_interval_timer pit_sva #(.OTHER_IRQS(OTHER_IRQS)) pit_sva_inst (.aclk, .aresetn,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rresp, .s_axi_rvalid,
  .s_axi_rready, .other_irq, .timer_irq, .system_irq);

/* File: test/slow_clock_source.sv */
// Partner model: the always-running slow clock and a count of its rising edges.
// Assumes the testbench reads the count to measure periods.
`timescale 1ns/1ps
module slow_clock_source (
  output logic slow_clock,
  output int   slow_edges
);
  // Never gated, and far slower than aclk
  initial begin
    slow_clock = 1'b0;
    forever #161.3 slow_clock = ~slow_clock;
  end
  initial begin
    slow_edges = 0;
    forever @(posedge slow_clock) slow_edges++;
  end
endmodule

/* File: test/tb.sv */
// Testbench for the periodic interval timer.
// Assumes the partner model supplies the slow clock.
`timescale 1ns/1ps
module tb;
  import interval_timer_pkg::*;
  logic        aclk = 1'b0;
  logic        aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, slow_clock, timer_irq, system_irq;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic [2:0]  other_irq;
  int          mismatches, n_tests, slow_edges, e1;
  periodic_interval_timer periodic_interval_timer_inst (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .slow_clock, .other_irq,
    .timer_irq, .system_irq);
  slow_clock_source slow_clock_source_inst (.slow_clock, .slow_edges);
  always #20 aclk = ~aclk;
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One bus access; wr selects write or read
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic [1:0] rs);
    int n;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_araddr  <= a;
    s_axi_wdata   <= wd;
    s_axi_awvalid <= wr;
    s_axi_wvalid  <= wr;
    s_axi_bready  <= wr;
    s_axi_arvalid <= !wr;
    s_axi_rready  <= !wr;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (wr ? s_axi_bvalid : s_axi_rvalid) break;
    end
    rd = s_axi_rdata;
    rs = wr ? s_axi_bresp : s_axi_rresp;
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
    if (n == 50) begin
      mismatches++;
      final_report();
    end
  endtask
  task automatic wait_irq(input logic lvl, input int lim);
    int n;
    for (n = 0; n < lim && timer_irq !== lvl; n++) begin
      @(posedge aclk);
    end
    chk(timer_irq, lvl);
    if (n == lim && timer_irq !== lvl) begin
      final_report();
    end
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, other_irq} = '0;
    s_axi_wstrb = 4'hF;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    xfer(0, OFFS_RELOAD, 0, d, r);
    chk(d, RESET_RELOAD);
    xfer(0, OFFS_INT_MASK, 0, d, r);
    chk(d, 0);
    // Shared line is quiet while the controller entry is set up
    chk(system_irq, 0);
    xfer(1, OFFS_INT_ENABLE, 1, d, r);
    chk(r, RESP_OKAY);
    xfer(0, OFFS_INT_MASK, 0, d, r);
    chk(d, 1);
    xfer(1, OFFS_RELOAD, 32'hABCD0003, d, r);
    wait_irq(1, 60);
    chk(system_irq, 1);
    e1 = slow_edges;
    xfer(0, OFFS_RELOAD, 0, d, r);
    chk(d, 32'h3);
    xfer(0, OFFS_STATUS, 0, d, r);
    chk(d, 1);
    xfer(0, OFFS_STATUS, 0, d, r);
    chk(d, 0);
    wait_irq(0, 8);
    wait_irq(1, 60);
    chk(slow_edges - e1, 3);
    xfer(1, OFFS_INT_DISABLE, 1, d, r);
    chk(r, RESP_OKAY);
    xfer(0, OFFS_INT_MASK, 0, d, r);
    chk(d, 0);
    xfer(0, OFFS_STATUS, 0, d, r);
    repeat (40) @(posedge aclk);
    chk(timer_irq, 0);
    xfer(0, OFFS_STATUS, 0, d, r);
    chk(d, 1);
    other_irq <= 3'h4;
    repeat (2) @(posedge aclk);
    chk(system_irq, 1);
    other_irq <= 3'h0;
    repeat (2) @(posedge aclk);
    chk(system_irq, 0);
    xfer(0, 8'h20, 0, d, r);
    chk(r, RESP_SLVERR);
    chk(d, 0);
    xfer(1, 8'h20, 1, d, r);
    chk(r, RESP_SLVERR);
    // Upper byte only: the low byte of the reload value is kept
    s_axi_wstrb <= 4'h2;
    xfer(1, OFFS_RELOAD, 32'h00001200, d, r);
    s_axi_wstrb <= 4'hF;
    xfer(0, OFFS_RELOAD, 0, d, r);
    chk(d, 32'h1203);
    // Reset in mid-run returns reload value and enable to zero
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    xfer(0, OFFS_RELOAD, 0, d, r);
    chk(d, RESET_RELOAD);
    xfer(0, OFFS_INT_MASK, 0, d, r);
    chk(d, 0);
    final_report();
  end
endmodule
